/* servo_front_pkg.sv */
// constants, field layouts and types for the servo command front end
//
// What this block does
// - one-touch tuning zeroes the mode code and loads the response level.
// - tuning mode codes 0, 1 and 3 accepted, each with its own auto set.
// - inertia estimated only in modes 0 and 1; manual value in mode 3.
// - response level 1 to 16, higher is faster; default 6.
// - in-position flag while error within window 0 to 65535, command units.
// - unit select 1 makes the window count encoder pulses.
// - positioning mode with unit select 0 means micrometres, else pulses.
// - ccw driving or cw regeneration clamped to forward cap, 0 to 100 %.
// - cw driving or ccw regeneration clamped to reverse cap, 0 to 100 %.
// - a cap of zero gives no torque in its quadrants.
// - new pulse form takes effect only at next power-up.
// - filter digit 0/1/2 allows 1M, 500k, 200k pulses per second.
// - three pulse input forms, each positive or negative logic.
// - quadrature input counts each single edge of either phase, four per cycle; edges on both phases in one cycle are flagged, not counted.
// - pulses per revolution may be given directly by its own register.
package servo_front_pkg;

  localparam int CLK_MHZ = 250;

  // register byte offsets
  localparam logic [7:0] OFF_MODE    = 8'h00;
  localparam logic [7:0] OFF_RESP    = 8'h04;
  localparam logic [7:0] OFF_WIN     = 8'h08;
  localparam logic [7:0] OFF_FWD     = 8'h0c;
  localparam logic [7:0] OFF_REV     = 8'h10;
  localparam logic [7:0] OFF_FMT     = 8'h14;
  localparam logic [7:0] OFF_PPR     = 8'h18;
  localparam logic [7:0] OFF_UNIT    = 8'h1c;
  localparam logic [7:0] OFF_INERTIA = 8'h20;
  localparam logic [7:0] OFF_CTRL    = 8'h24;
  localparam logic [7:0] OFF_STAT    = 8'h28;
  localparam logic [7:0] OFF_IRQ_ST  = 8'h2c;
  localparam logic [7:0] OFF_IRQ_MSK = 8'h30;
  localparam logic [7:0] OFF_COUNT   = 8'h34;

  // reset values
  localparam logic [11:0] RST_MODE    = 12'h001;
  localparam logic [15:0] RST_RESP    = 16'h0006;
  localparam logic [15:0] RST_WIN     = 16'h0064;
  localparam logic [15:0] RST_CAP     = 16'h0064;
  localparam logic [11:0] RST_FMT     = 12'h000;
  localparam logic [15:0] RST_PPR     = 16'h0000;
  localparam logic [15:0] RST_INERTIA = 16'h0046;

  // field positions and legal values
  localparam int FMT_POL_LSB  = 4;
  localparam int FMT_FILT_LSB = 8;
  localparam logic [3:0] MODE_TWO_GAIN = 4'h0;
  localparam logic [3:0] MODE_AUTO1    = 4'h1;
  localparam logic [3:0] MODE_MANUAL   = 4'h3;
  localparam logic [15:0] RESP_MIN = 16'h0001;
  localparam logic [15:0] RESP_MAX = 16'h0010;
  localparam logic [15:0] CAP_MAX  = 16'h0064;
  localparam logic [3:0] FORM_FWD_REV    = 4'h0;
  localparam logic [3:0] FORM_PULSE_SIGN = 4'h1;
  localparam logic [3:0] FORM_QUAD       = 4'h2;
  localparam logic [3:0] POL_NEG         = 4'h1;
  localparam logic [3:0] FILT_1M   = 4'h0;
  localparam logic [3:0] FILT_500K = 4'h1;
  localparam logic [3:0] FILT_200K = 4'h2;

  // noise filter settle times, a quarter of the shortest pulse period
  localparam int FILT_1M_NS   = 250;
  localparam int FILT_500K_NS = 500;
  localparam int FILT_200K_NS = 1250;
  localparam logic [8:0] FILT_1M_CYC   = 9'(FILT_1M_NS * CLK_MHZ / 1000);
  localparam logic [8:0] FILT_500K_CYC = 9'(FILT_500K_NS * CLK_MHZ / 1000);
  localparam logic [8:0] FILT_200K_CYC = 9'(FILT_200K_NS * CLK_MHZ / 1000);

  // interrupt bits
  localparam int IRQ_W     = 4;
  localparam int IRQ_INPOS = 0;
  localparam int IRQ_TUNE  = 1;
  localparam int IRQ_CLAMP = 2;
  localparam int IRQ_QUAD  = 3;

  // in-position unit codes
  localparam logic [1:0] UNIT_CMD = 2'h0;
  localparam logic [1:0] UNIT_ENC = 2'h1;
  localparam logic [1:0] UNIT_UM  = 2'h2;

  typedef enum logic [0:0] {tune_idle, tune_run} tune_state_type;

endpackage

/* servo_front.sv */
// servo command front end: tuning, in-position, torque caps, pulse decode
`timescale 1ns/1ps
module servo_front
  import servo_front_pkg::*;
#(
  parameter logic [15:0] TORQUE_FULL = 16'h7fff
)(
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  // power cycle notice for deferred settings
  input  wire logic               power_on_event,
  // command pulse pins
  input  wire logic               pulse_a,
  input  wire logic               pulse_b,
  // loop side inputs
  input  wire logic signed [31:0] pos_error_command,
  input  wire logic signed [31:0] pos_error_encoder,
  input  wire logic signed [15:0] torque_request,
  input  wire logic [15:0]        inertia_estimate,
  input  wire logic               one_touch_done,
  input  wire logic [15:0]        one_touch_level,
  // outputs to the loop
  output logic signed [15:0]      torque_command,
  output logic                    in_position_flag,
  output logic [1:0]              in_position_unit,
  output logic [15:0]             inertia_ratio,
  output logic                    estimate_enable,
  output logic                    auto_model_gain,
  output logic                    auto_loop_gain,
  output logic                    one_touch_busy,
  output logic [15:0]             pulses_per_rev_direct,
  output logic signed [31:0]      command_count,
  output logic                    count_up,
  output logic                    count_down,
  output logic                    irq
);

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic                pready;
    logic [31:0]         prdata;
    logic                pslverr;
    logic [11:0]         mode_sel;
    logic [15:0]         resp;
    logic [15:0]         win;
    logic [15:0]         fwd_cap;
    logic [15:0]         rev_cap;
    logic [11:0]         fmt_pend;
    logic [11:0]         fmt_act;
    logic [15:0]         ppr;
    logic                unit_sel;
    logic                posn_mode;
    logic [15:0]         inertia_man;
    logic [IRQ_W-1:0]    irq_st;
    logic [IRQ_W-1:0]    irq_mask;
    tune_state_type      tune;
    logic                sa1;
    logic                sa2;
    logic                sb1;
    logic                sb2;
    logic                fa;
    logic                fb;
    logic [8:0]          ca;
    logic [8:0]          cb;
    logic                pa;
    logic                pb;
    logic signed [31:0]  count;
    logic                up;
    logic                dn;
    logic                inpos;
    logic [1:0]          unit;
    logic [15:0]         inertia;
    logic                est_en;
    logic                auto_model;
    logic                auto_loop;
    logic signed [15:0]  torque;
    logic                irq;
  } state_type;

  state_type s;
  state_type next_s;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // one filter step: a new level is taken once it has held long enough
  function automatic logic [9:0] filt_step(input logic       raw,
                                           input logic       cur,
                                           input logic [8:0] cnt,
                                           input logic [8:0] lim);
    logic [9:0] r;
    r = {cur, 9'h000};
    if (raw != cur)
    begin
      if (cnt >= lim)
        r = {raw, 9'h000};
      else
        r = {cur, 9'(cnt + 9'h001)};
    end
    return r;
  endfunction

  // magnitude of a signed error
  function automatic logic [31:0] mag(input logic signed [31:0] e);
    return e[31] ? 32'(-e) : 32'(e);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // combinational helpers

  logic               acc;
  logic               done;
  logic               bad;
  logic [31:0]        rd_val;
  logic [3:0]         wcode;
  logic [3:0]         form;
  logic               neg;
  logic [3:0]         filt;
  logic [8:0]         flim;
  logic [9:0]         sa_res;
  logic [9:0]         sb_res;
  logic               la;
  logic               lb;
  logic               lpa;
  logic               lpb;
  logic               step;
  logic               step_up;
  logic               quad_err;
  logic [31:0]        fwd_lim;
  logic [31:0]        rev_lim;
  logic signed [16:0] req;
  logic               clamp;
  logic [31:0]        err;
  logic [IRQ_W-1:0]   ev;

  always_comb
  begin
    next_s   = s;
    rd_val   = 32'h00000000;
    bad      = 1'b0;
    wcode    = pwdata[3:0];
    ev       = '0;
    step     = 1'b0;
    step_up  = 1'b0;
    quad_err = 1'b0;
    clamp    = 1'b0;

    // apb decode; writes are checked against legal ranges
    case (paddr)
      OFF_MODE:    rd_val = {20'h00000, s.mode_sel};
      OFF_RESP:    rd_val = {16'h0000, s.resp};
      OFF_WIN:     rd_val = {16'h0000, s.win};
      OFF_FWD:     rd_val = {16'h0000, s.fwd_cap};
      OFF_REV:     rd_val = {16'h0000, s.rev_cap};
      OFF_FMT:     rd_val = {20'h00000, s.fmt_pend};
      OFF_PPR:     rd_val = {16'h0000, s.ppr};
      OFF_UNIT:    rd_val = {30'h00000000, s.posn_mode, s.unit_sel};
      OFF_INERTIA: rd_val = {16'h0000, s.inertia_man};
      OFF_CTRL:    rd_val = {31'h00000000, s.tune == tune_run};
      OFF_STAT:    rd_val = {16'h0000, s.fmt_act, 1'b0, s.unit, s.inpos};
      OFF_IRQ_ST:  rd_val = {28'h0000000, s.irq_st};
      OFF_IRQ_MSK: rd_val = {28'h0000000, s.irq_mask};
      OFF_COUNT:   rd_val = s.count;
      default:     bad = 1'b1;
    endcase
    if (pwrite)
    begin
      unique case (paddr)
        // only codes 0, 1 and 3 are accepted
        OFF_MODE:
          bad = !(wcode == MODE_TWO_GAIN || wcode == MODE_AUTO1 ||
                  wcode == MODE_MANUAL);
        OFF_RESP:
          bad = pwdata[15:0] < RESP_MIN || pwdata[15:0] > RESP_MAX;
        // forward cap 0 to 100 percent
        OFF_FWD: bad = pwdata[15:0] > CAP_MAX;
        // reverse cap 0 to 100 percent
        OFF_REV: bad = pwdata[15:0] > CAP_MAX;
        // form 0..2, polarity 0..1, filter 0..2
        OFF_FMT:
          bad = pwdata[3:0] > FORM_QUAD ||
                pwdata[FMT_POL_LSB+:4] > POL_NEG ||
                pwdata[FMT_FILT_LSB+:4] > FILT_200K;
        OFF_STAT:  bad = 1'b1;
        OFF_COUNT: bad = 1'b1;
        default: ;
      endcase
    end

    // apb handshake with one wait state
    acc            = psel && penable;
    done           = acc && s.pready;
    next_s.pready  = acc && !s.pready;
    next_s.pslverr = acc && !s.pready && bad;
    next_s.prdata  = (acc && !s.pready && !pwrite) ? rd_val : 32'h00000000;

    // register writes at the completing edge
    if (done && pwrite && !bad)
    begin
      unique case (paddr)
        OFF_MODE:    next_s.mode_sel    = pwdata[11:0];
        OFF_RESP:    next_s.resp        = pwdata[15:0];
        OFF_WIN:     next_s.win         = pwdata[15:0];
        OFF_FWD:     next_s.fwd_cap     = pwdata[15:0];
        OFF_REV:     next_s.rev_cap     = pwdata[15:0];
        // stored now, used after the next power-up
        OFF_FMT:     next_s.fmt_pend    = pwdata[11:0];
        OFF_PPR:     next_s.ppr         = pwdata[15:0];
        OFF_UNIT:
        begin
          next_s.unit_sel  = pwdata[0];
          next_s.posn_mode = pwdata[1];
        end
        OFF_INERTIA: next_s.inertia_man = pwdata[15:0];
        OFF_CTRL:
        begin
          // one-touch start forces the mode code to zero
          if (pwdata[0])
          begin
            next_s.tune          = tune_run;
            next_s.mode_sel[3:0] = MODE_TWO_GAIN;
          end
        end
        OFF_IRQ_ST:  next_s.irq_st   = s.irq_st & ~pwdata[IRQ_W-1:0];
        OFF_IRQ_MSK: next_s.irq_mask = pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end

    // pulse form taken over only on a power cycle
    if (power_on_event)
      next_s.fmt_act = s.fmt_pend;

    // tuning result loads the response level
    if (s.tune == tune_run && one_touch_done)
    begin
      next_s.tune = tune_idle;
      ev[IRQ_TUNE] = 1'b1;
      if (one_touch_level >= RESP_MIN && one_touch_level <= RESP_MAX)
        next_s.resp = one_touch_level;
    end

    // which gains the loop sets by itself
    next_s.auto_model = s.mode_sel[3:0] == MODE_AUTO1;
    next_s.auto_loop  = s.mode_sel[3:0] != MODE_MANUAL;
    // estimate or stored manual inertia ratio
    next_s.est_en  = s.mode_sel[3:0] != MODE_MANUAL;
    next_s.inertia = (s.mode_sel[3:0] != MODE_MANUAL) ?
                     inertia_estimate : s.inertia_man;

    // two-stage synchroniser on each pulse pin
    next_s.sa1 = pulse_a;
    next_s.sa2 = s.sa1;
    next_s.sb1 = pulse_b;
    next_s.sb2 = s.sb1;

    // filter length from the filter digit
    form = s.fmt_act[3:0];
    neg  = s.fmt_act[FMT_POL_LSB+:4] == POL_NEG;
    filt = s.fmt_act[FMT_FILT_LSB+:4];
    unique case (filt)
      FILT_500K: flim = FILT_500K_CYC;
      FILT_200K: flim = FILT_200K_CYC;
      default:   flim = FILT_1M_CYC;
    endcase
    sa_res    = filt_step(s.sa2, s.fa, s.ca, flim);
    sb_res    = filt_step(s.sb2, s.fb, s.cb, flim);
    next_s.fa = sa_res[9];
    next_s.ca = sa_res[8:0];
    next_s.fb = sb_res[9];
    next_s.cb = sb_res[8:0];
    next_s.pa = s.fa;
    next_s.pb = s.fb;

    // logic polarity applied to both phases
    la  = s.fa ^ neg;
    lb  = s.fb ^ neg;
    lpa = s.pa ^ neg;
    lpb = s.pb ^ neg;

    unique case (form)
      FORM_PULSE_SIGN:
      begin
        step    = la && !lpa;
        step_up = !lb;
      end
      FORM_QUAD:
      begin
        // every single edge of either phase counts; edges on both phases in one cycle are flagged, not counted
        quad_err = (la != lpa) && (lb != lpb);
        step     = ((la != lpa) != (lb != lpb));
        step_up  = la ^ lpb;
      end
      default:
      begin
        step    = (la && !lpa) != (lb && !lpb);
        step_up = la && !lpa;
      end
    endcase
    ev[IRQ_QUAD] = quad_err;
    next_s.up    = step && step_up;
    next_s.dn    = step && !step_up;
    if (step)
      next_s.count = step_up ? s.count + 32'sd1 : s.count - 32'sd1;

    // unit select chooses encoder or command error
    err = s.unit_sel ? mag(pos_error_encoder) : mag(pos_error_command);
    // flag held while within the window
    next_s.inpos = err <= {16'h0000, s.win};
    ev[IRQ_INPOS] = next_s.inpos && !s.inpos;
    // micrometres only in positioning mode with unit select 0
    if (s.unit_sel)
      next_s.unit = UNIT_ENC;
    else if (s.posn_mode)
      next_s.unit = UNIT_UM;
    else
      next_s.unit = UNIT_CMD;

    // torque caps scaled from percent of full torque
    fwd_lim = (32'(s.fwd_cap) * 32'(TORQUE_FULL)) / 32'd100;
    rev_lim = (32'(s.rev_cap) * 32'(TORQUE_FULL)) / 32'd100;
    req     = 17'(torque_request);
    next_s.torque = torque_request;
    // positive torque is ccw driving or cw regeneration
    if (req > $signed({1'b0, fwd_lim[15:0]}))
    begin
      next_s.torque = $signed(fwd_lim[15:0]);
      clamp         = 1'b1;
    end
    // negative torque is cw driving or ccw regeneration
    if (req < -$signed({1'b0, rev_lim[15:0]}))
    begin
      next_s.torque = 16'(-$signed({1'b0, rev_lim[15:0]}));
      clamp         = 1'b1;
    end
    ev[IRQ_CLAMP] = clamp;

    // sticky events: a set wins over a same-cycle clear
    next_s.irq_st = next_s.irq_st | ev;
    next_s.irq    = |(s.irq_st & s.irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s             <= '0;
      s.mode_sel    <= RST_MODE;
      s.resp        <= RST_RESP;
      s.win         <= RST_WIN;
      s.fwd_cap     <= RST_CAP;
      s.rev_cap     <= RST_CAP;
      s.fmt_pend    <= RST_FMT;
      s.fmt_act     <= RST_FMT;
      s.ppr         <= RST_PPR;
      s.inertia_man <= RST_INERTIA;
      s.tune        <= tune_idle;
    end
    else
      s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign pready                = s.pready;
  assign prdata                = s.prdata;
  assign pslverr               = s.pslverr;
  assign torque_command        = s.torque;
  assign in_position_flag      = s.inpos;
  assign in_position_unit      = s.unit;
  assign inertia_ratio         = s.inertia;
  assign estimate_enable       = s.est_en;
  assign auto_model_gain       = s.auto_model;
  assign auto_loop_gain        = s.auto_loop;
  assign one_touch_busy        = s.tune == tune_run;
  assign pulses_per_rev_direct = s.ppr;
  assign command_count         = s.count;
  assign count_up              = s.up;
  assign count_down            = s.dn;
  assign irq                   = s.irq;

endmodule // servo_front

/* servo_front_checker.sv */
// port assertions for the servo command front end
`timescale 1ns/1ps
module servo_front_checker (
  // clock, reset and bus answer
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pready,
  input wire logic               pslverr,
  // loop side
  input wire logic signed [15:0] torque_request,
  input wire logic signed [15:0] torque_command,
  input wire logic signed [31:0] pos_error_command,
  input wire logic signed [31:0] pos_error_encoder,
  input wire logic               in_position_flag,
  input wire logic [1:0]         in_position_unit,
  input wire logic               estimate_enable,
  input wire logic               auto_loop_gain,
  input wire logic               auto_model_gain,
  input wire logic               one_touch_done,
  input wire logic               one_touch_busy,
  // pulse counter
  input wire logic signed [31:0] command_count,
  input wire logic               count_up,
  input wire logic               count_down
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////
  // bus answer timing, exactly one wait state
  apb_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("bus answer late or early");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_qual_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  ////////////////////////////////////////////////////////////////////////
  // torque keeps sign and never exceeds the request
  fwd_clamp_a: assert property (torque_request >= 0 |=>
    torque_command >= 0 && torque_command <= $past(torque_request))
    else $error("forward torque above request");
  rev_clamp_a: assert property (torque_request < 0 |=>
    torque_command <= 0 && torque_command >= $past(torque_request))
    else $error("reverse torque above request");
  ////////////////////////////////////////////////////////////////////////
  // zero error always lies inside any window
  inpos_zero_a: assert property (pos_error_command == 0 &&
    pos_error_encoder == 0 |=> in_position_flag)
    else $error("zero error not in position");
  unit_code_a: assert property (in_position_unit != 2'h3)
    else $error("bad unit code");
  mode_gain_a: assert property (auto_model_gain |->
    estimate_enable && auto_loop_gain)
    else $error("model gain auto outside mode one");
  busy_end_a: assert property ($fell(one_touch_busy) |->
    $past(one_touch_done))
    else $error("tuning ended without done");
  ////////////////////////////////////////////////////////////////////////
  // counter moves one step at a time
  count_step_a: assert property ($changed(command_count) |->
    count_up ? command_count - $past(command_count) == 1 :
    count_down && command_count - $past(command_count) == -1)
    else $error("count jumped");
  count_excl_a: assert property (!(count_up && count_down))
    else $error("up and down together");
endmodule // servo_front_checker

/* pulse_host.sv */
// host controller model driving command pulse trains
`timescale 1ns/1ps
module pulse_host (
  // clock and polarity
  input  wire logic clk,
  input  wire logic neg,
  // pulse pins
  output logic      pulse_a,
  output logic      pulse_b
);
  logic a_lvl = 1'b0;
  logic b_lvl = 1'b0;

  assign pulse_a = a_lvl ^ neg;
  assign pulse_b = b_lvl ^ neg;

  // half period in cycles keeps the rate under the filter limit
  // quadrature toggles a then b, or b then a when going down
  task automatic send(input int form, input int n, input bit dn,
                      input int half);
  begin
    b_lvl <= (form == 1) ? dn : 1'b0;
    repeat (half) @(posedge clk);
    repeat (n)
    begin
      for (int k = 0; k < 4; k++)
      begin
        if (form != 2 && k > 1)
          break;
        if (form == 2 ? (dn ^ k[0]) : (form == 0 && dn))
          b_lvl <= ~b_lvl;
        else
          a_lvl <= ~a_lvl;
        repeat (half) @(posedge clk);
      end
    end
  end
  endtask

  // spike on phase a, narrower than the filter
  task automatic glitch(input int len);
  begin
    a_lvl <= 1'b1;
    repeat (len) @(posedge clk);
    a_lvl <= 1'b0;
    repeat (len) @(posedge clk);
  end
  endtask
endmodule // pulse_host

/* servo_front_tb.sv */
// self-checking bench for the servo command front end
`timescale 1ns/1ps
module servo_front_tb;
  import servo_front_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, host_neg;
  logic power_on_event, pulse_a, pulse_b, one_touch_done, irq;
  logic in_position_flag, estimate_enable, auto_model_gain;
  logic auto_loop_gain, one_touch_busy, count_up, count_down, re;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic signed [31:0] pos_error_command, pos_error_encoder, command_count;
  logic signed [15:0] torque_request, torque_command;
  logic [15:0] inertia_estimate, one_touch_level, inertia_ratio;
  logic [15:0] pulses_per_rev_direct;
  logic [1:0] in_position_unit;
  int mismatches, checked, base;

  servo_front u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .power_on_event, .pulse_a,
    .pulse_b, .pos_error_command, .pos_error_encoder, .torque_request,
    .inertia_estimate, .one_touch_done, .one_touch_level, .torque_command,
    .in_position_flag, .in_position_unit, .inertia_ratio, .estimate_enable,
    .auto_model_gain, .auto_loop_gain, .one_touch_busy,
    .pulses_per_rev_direct, .command_count, .count_up, .count_down, .irq);
  pulse_host u_host (.clk(pclk), .neg(host_neg), .pulse_a, .pulse_b);

  ////////////////////////////////////////////////////////////////////////
  // compare, bus cycle and finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  end
  endtask

  task automatic stop_test;
  begin
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
  begin
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20)
    begin
      mismatches++;
      stop_test();
    end
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  end
  endtask

  // write, check the refusal flag
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic e);
  begin
    apb(1'b1, a, d);
    chk(32'(re), 32'(e));
  end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
  begin
    apb(1'b0, a, 32'h0);
    chk(rv, e);
  end
  endtask

  task automatic power_up;
  begin
    power_on_event <= 1'b1;
    @(posedge pclk);
    power_on_event <= 1'b0;
    repeat (400) @(posedge pclk);
  end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs;
  begin
    rdc(OFF_MODE, 32'h001);
    rdc(OFF_RESP, 32'h006);
    rdc(OFF_WIN, 32'h064);
    rdc(OFF_FWD, 32'h064);
    rdc(OFF_REV, 32'h064);
    rdc(OFF_FMT, 32'h000);
    wr(OFF_PPR, 32'h1388, 1'b0);
    chk(32'(pulses_per_rev_direct), 32'h1388);
    apb(1'b0, 8'h3c, 32'h0);
    chk({31'h0, re}, 32'h1);
    wr(OFF_MODE, 32'h002, 1'b1);
    $display("registers done");
  end
  endtask

  task automatic t_modes;
    logic [3:0] m [3] = '{4'h0, 4'h1, 4'h3};
  begin
    inertia_estimate <= 16'h0123;
    for (int i = 0; i < 3; i++)
    begin
      wr(OFF_MODE, 32'(m[i]), 1'b0);
      @(posedge pclk);
      chk({estimate_enable, auto_loop_gain, auto_model_gain},
          {m[i] != 4'h3, m[i] != 4'h3, m[i] == 4'h1});
      chk(inertia_ratio, m[i] == 4'h3 ? 16'h0046 : 16'h0123);
    end
    $display("tuning modes done");
  end
  endtask

  task automatic t_tune;
  begin
    wr(OFF_IRQ_MSK, 32'h0, 1'b0);
    wr(OFF_CTRL, 32'h1, 1'b0);
    rdc(OFF_MODE, 32'h000);
    chk(32'(one_touch_busy), 32'h1);
    one_touch_level <= 16'h0009;
    one_touch_done <= 1'b1;
    @(posedge pclk);
    one_touch_done <= 1'b0;
    rdc(OFF_RESP, 32'h009);
    chk({one_touch_busy, irq}, 2'b00);
    wr(OFF_IRQ_MSK, 32'h2, 1'b0);
    @(posedge pclk);
    chk(32'(irq), 32'h1);
    wr(OFF_IRQ_ST, 32'h2, 1'b0);
    @(posedge pclk);
    chk(32'(irq), 32'h0);
    wr(OFF_RESP, 32'h11, 1'b1);
    wr(OFF_RESP, 32'h0, 1'b1);
    wr(OFF_RESP, 32'h10, 1'b0);
    rdc(OFF_RESP, 32'h010);
    $display("one-touch done");
  end
  endtask

  task automatic t_inpos;
    int e [4] = '{100, 101, -100, -101};
  begin
    for (int i = 0; i < 4; i++)
    begin
      pos_error_command <= e[i];
      repeat (3) @(posedge pclk);
      chk(32'(in_position_flag), 32'(i % 2 == 0));
    end
    pos_error_command <= 0;
    pos_error_encoder <= 500;
    wr(OFF_UNIT, 32'h1, 1'b0);
    @(posedge pclk);
    chk({in_position_flag, in_position_unit}, {1'b0, UNIT_ENC});
    wr(OFF_UNIT, 32'h2, 1'b0);
    @(posedge pclk);
    chk(32'(in_position_unit), 32'(UNIT_UM));
    wr(OFF_UNIT, 32'h3, 1'b0);
    @(posedge pclk);
    chk(32'(in_position_unit), 32'(UNIT_ENC));
    pos_error_encoder <= 0;
    $display("in-position done");
  end
  endtask

  task automatic t_torque;
    int q [4] = '{30000, 10000, -5000, -32767};
    int x [4] = '{50 * 32767 / 100, 10000, 0, -32767};
  begin
    wr(OFF_FWD, 32'd101, 1'b1);
    wr(OFF_FWD, 32'd50, 1'b0);
    wr(OFF_REV, 32'd0, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      if (i == 3)
        wr(OFF_REV, 32'd100, 1'b0);
      torque_request <= 16'(q[i]);
      repeat (3) @(posedge pclk);
      chk(32'(torque_command), 32'(x[i]));
    end
    rdc(OFF_IRQ_ST, 32'h5);
    torque_request <= 16'sh0;
    $display("torque caps done");
  end
  endtask

  task automatic t_pulse;
  begin
    base = command_count;
    u_host.send(0, 3, 1'b0, 125);
    u_host.send(0, 2, 1'b1, 125);
    chk(command_count, base + 1);
    wr(OFF_FMT, 32'h102, 1'b0);
    u_host.send(0, 1, 1'b0, 125);
    chk(command_count, base + 2);
    power_up();
    u_host.send(2, 2, 1'b0, 250);
    repeat (100) @(posedge pclk);
    chk(command_count, base + 10);
    u_host.send(2, 2, 1'b1, 250);
    repeat (100) @(posedge pclk);
    chk(command_count, base + 2);
    wr(OFF_FMT, 32'h211, 1'b0);
    power_up();
    host_neg <= 1'b1;
    repeat (400) @(posedge pclk);
    base = command_count;
    u_host.send(1, 2, 1'b0, 625);
    u_host.send(1, 1, 1'b1, 625);
    u_host.glitch(50);
    repeat (400) @(posedge pclk);
    chk(command_count, base + 1);
    $display("pulse decode done");
  end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // clock, reset and sequence
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  initial
  begin
    {presetn, psel, penable, pwrite, power_on_event} = '0;
    {one_touch_done, host_neg, paddr, pwdata} = '0;
    {pos_error_command, pos_error_encoder, torque_request} = '0;
    {inertia_estimate, one_touch_level} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_modes();
    t_tune();
    t_inpos();
    t_torque();
    t_pulse();
    stop_test();
  end
endmodule // servo_front_tb

bind servo_front servo_front_checker u_chk (.pclk, .presetn, .psel,
  .penable, .pready, .pslverr, .torque_request, .torque_command,
  .pos_error_command, .pos_error_encoder, .in_position_flag,
  .in_position_unit, .estimate_enable, .auto_loop_gain, .auto_model_gain,
  .one_touch_done, .one_touch_busy, .command_count, .count_up, .count_down);
